// *** core/msrm_pkg.sv ***
package msrm_pkg;
    // ==================================================
    // register offsets (8-bit bus, byte addresses)
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_REG_BASE = 8'h01;
    localparam logic [7:0] ADDR_RAM_BASE = 8'h02;
    localparam logic [7:0] ADDR_EE_BASE = 8'h03;
    localparam logic [7:0] ADDR_DBG_CTL = 8'h04;
    localparam logic [7:0] ADDR_DBG_STAT = 8'h05;
    localparam logic [7:0] ADDR_FLASH_BASE = 8'h06;
    // ==================================================
    // reset values of the mapping registers (upper address nibble)
    localparam logic [3:0] RST_REG_BASE = 4'h0;
    localparam logic [3:0] RST_RAM_BASE = 4'h8;
    localparam logic [3:0] RST_EE_BASE = 4'h1;
    localparam logic [3:0] RST_FLASH_BASE = 4'h8;
    // ==================================================
    // resource sizes as address masks, top region
    localparam logic [15:0] REG_MASK = 16'hfc00;
    localparam logic [15:0] RAM_MASK = 16'hfc00;
    localparam logic [15:0] EE_MASK = 16'hfc00;
    localparam logic [15:0] FLASH_MASK = 16'h8000;
    localparam logic [15:0] DBG_ROM_BASE = 16'hff00;
    localparam logic [15:0] DBG_ROM_MASK = 16'hff00;
    localparam logic [15:0] DBG_REG_LAST = 16'hff06;
    // ==================================================
    // field positions in the mode, debug control and mapping registers
    localparam int MODE_BIT_N = 2;
    localparam int DBG_EN_BIT = 0;
    localparam int DBG_ACT_BIT = 1;
    localparam int MAP_EN_BIT = 7;

    typedef enum logic [2:0] {
        MSRM_SSC = 3'h0, MSRM_SXN = 3'h1, MSRM_SPR = 3'h2, MSRM_SXW = 3'h3,
        MSRM_NSC = 3'h4, MSRM_NXN = 3'h5, MSRM_NRS = 3'h6, MSRM_NXW = 3'h7
    } msrm_mode_t;

    typedef enum logic [2:0] {
        MSRM_SEL_NONE, MSRM_SEL_EXT, MSRM_SEL_DBG, MSRM_SEL_REG,
        MSRM_SEL_RAM, MSRM_SEL_EE, MSRM_SEL_FLASH
    } msrm_sel_t;

    typedef enum logic [1:0] {
        MSRM_PORT_GPIO, MSRM_PORT_NARROW, MSRM_PORT_WIDE
    } msrm_port_t;

    typedef struct packed {
        logic [15:0] addr;
        logic valid;
        logic vector;
        logic serial;
        logic write;
    } msrm_acc_t;
endpackage

// *** core/msrm_core.sv ***
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// ==================================================
module msrm_core import msrm_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic debug_strap_pin,
    input wire logic mode_strap_high,
    input wire logic mode_strap_low,
    output logic debug_strap_oe,
    output logic debug_strap_out,
    output logic mode_strap_oe,
    output logic mode_strap_out,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire msrm_acc_t acc,
    input wire logic serial_enter,
    input wire logic enter_debug_instruction,
    input wire logic bus_idle,
    output logic [2:0] acc_sel,
    output logic acc_grant,
    output logic [2:0] mode_out,
    output logic [1:0] port_func,
    output logic cpu_hold,
    output logic ext_master_en,
    output logic special_mode,
    output logic debug_active
);
    // ==================================================
    // strap capture and mode state
    logic strap_take_ff;
    logic [2:0] mode_ff;
    logic dbg_en_ff, dbg_act_ff;
    logic [3:0] reg_base_ff, ram_base_ff, ee_base_ff, flash_base_ff;
    logic [3:0] wr_once_ff;
    logic [7:0] rdata_ff;
    logic [2:0] sel_ff;
    logic grant_ff;

    // pulls are on while reset is low and until the first clock edge after release; a clocked flop holds them off afterwards
    logic pull_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pull_ff <= 1'b1;
        end else begin
            pull_ff <= 1'b0;
        end
    end
    assign debug_strap_oe = pull_ff;
    assign debug_strap_out = 1'b1;
    assign mode_strap_oe = pull_ff;
    assign mode_strap_out = 1'b0;

    function automatic logic [2:0] fix_mode(input logic [2:0] m);
        fix_mode = (m == MSRM_NRS) ? MSRM_SPR : m;
    endfunction

    function automatic logic is_special(input logic [2:0] m);
        is_special = ~m[MODE_BIT_N];
    endfunction

    function automatic logic is_periph(input logic [2:0] m);
        is_periph = (m == MSRM_SPR);
    endfunction

    wire [2:0] strap_mode = fix_mode({debug_strap_pin, mode_strap_high, mode_strap_low});
    wire special = is_special(mode_ff);
    wire periph = is_periph(mode_ff);
    wire expanded = mode_ff[0] | (mode_ff[1] & ~periph);

    // ==================================================
    // register decode
    wire wr_mode = wr && addr == ADDR_MODE;
    wire wr_reg = wr && addr == ADDR_REG_BASE;
    wire wr_ram = wr && addr == ADDR_RAM_BASE;
    wire wr_ee = wr && addr == ADDR_EE_BASE;
    wire wr_fl = wr && addr == ADDR_FLASH_BASE;
    wire wr_dbg = wr && addr == ADDR_DBG_CTL;
    wire [3:0] map_wr = {wr_fl, wr_ee, wr_ram, wr_reg};
    wire [3:0] map_ok = map_wr & (special ? 4'hf : ~wr_once_ff);

    // mode change allowed only from a special non-peripheral mode to a non-peripheral mode, peripheral fixed
    wire [2:0] req_mode = fix_mode({~wdata[MODE_BIT_N], wdata[1:0]});
    wire mode_ok = wr_mode && special && !periph && !is_periph(req_mode);

    wire dbg_entry = dbg_en_ff && (serial_enter || enter_debug_instruction) && !periph;
    // an entry request in the same cycle as a software exit wins, so no request is lost
    wire dbg_exit = wr_dbg && !wdata[DBG_ACT_BIT];
    wire nxt_dbg_act = dbg_entry | (dbg_act_ff & !dbg_exit);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strap_take_ff <= 1'b1;
        end else begin
            strap_take_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_ff <= MSRM_NSC;
            dbg_en_ff <= 1'b0;
            dbg_act_ff <= 1'b0;
        end else if (strap_take_ff) begin
            mode_ff <= strap_mode;
            dbg_en_ff <= (strap_mode == MSRM_SSC);
            dbg_act_ff <= (strap_mode == MSRM_SSC);
        end else begin
            if (mode_ok) begin
                mode_ff <= req_mode;
            end
            if (wr_dbg) begin
                dbg_en_ff <= wdata[DBG_EN_BIT];
            end
            dbg_act_ff <= nxt_dbg_act;
        end
    end

    // ==================================================
    // mapping registers, new value live from the next cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_base_ff <= RST_REG_BASE;
            ram_base_ff <= RST_RAM_BASE;
            ee_base_ff <= RST_EE_BASE;
            flash_base_ff <= RST_FLASH_BASE;
            wr_once_ff <= 4'h0;
        end else begin
            if (map_ok[0]) reg_base_ff <= wdata[MAP_EN_BIT -: 4];
            if (map_ok[1]) ram_base_ff <= wdata[MAP_EN_BIT -: 4];
            if (map_ok[2]) ee_base_ff <= wdata[MAP_EN_BIT -: 4];
            if (map_ok[3]) flash_base_ff <= wdata[MAP_EN_BIT -: 4];
            wr_once_ff <= wr_once_ff | map_wr;
        end
    end

    // ==================================================
    // read port
    wire [7:0] rd_mux =
        (addr == ADDR_MODE) ? {5'h0, ~mode_ff[MODE_BIT_N], mode_ff[1:0]} :
        (addr == ADDR_REG_BASE) ? {reg_base_ff, 4'h0} :
        (addr == ADDR_RAM_BASE) ? {ram_base_ff, 4'h0} :
        (addr == ADDR_EE_BASE) ? {ee_base_ff, 4'h0} :
        (addr == ADDR_FLASH_BASE) ? {flash_base_ff, 4'h0} :
        (addr == ADDR_DBG_CTL) ? {6'h0, dbg_act_ff, dbg_en_ff} :
        (addr == ADDR_DBG_STAT) ? {4'h0, wr_once_ff} : 8'h00;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= rd ? rd_mux : 8'h00;
        end
    end

    // ==================================================
    // address decode
    function automatic logic hit(input logic [15:0] a, input logic [3:0] base, input logic [15:0] mask);
        hit = ((a & mask) == ({base, 12'h000} & mask));
    endfunction

    wire in_top = (acc.addr & DBG_ROM_MASK) == DBG_ROM_BASE;
    wire h_reg = hit(acc.addr, reg_base_ff, REG_MASK);
    wire h_ram = hit(acc.addr, ram_base_ff, RAM_MASK);
    wire h_ee = hit(acc.addr, ee_base_ff, EE_MASK);
    wire h_fl = hit(acc.addr, flash_base_ff, FLASH_MASK);
    wire nvm = !h_reg && !h_ram && (h_ee || h_fl);
    // cpu in debug sees the rom on top; serial keeps user view
    wire use_rom = dbg_act_ff && !acc.serial && (in_top || acc.vector);
    // serial accesses steal idle cycles and cannot write nonvolatile storage
    wire ser_ok = bus_idle && !(acc.write && nvm);
    wire cpu_ok = !periph;

    wire [2:0] nxt_sel =
        !acc.valid ? MSRM_SEL_NONE :
        use_rom ? MSRM_SEL_DBG :
        h_reg ? MSRM_SEL_REG :
        h_ram ? MSRM_SEL_RAM :
        h_ee ? MSRM_SEL_EE :
        h_fl ? MSRM_SEL_FLASH :
        expanded ? MSRM_SEL_EXT : MSRM_SEL_NONE;
    wire nxt_grant = acc.valid && (acc.serial ? ser_ok : (cpu_ok || periph));

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= MSRM_SEL_NONE;
            grant_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            grant_ff <= nxt_grant;
        end
    end

    // ==================================================
    // outputs
    wire [1:0] nxt_port = (mode_ff == MSRM_SSC || mode_ff == MSRM_NSC) ? MSRM_PORT_GPIO :
                          mode_ff[1] ? MSRM_PORT_WIDE : MSRM_PORT_NARROW;
    logic [1:0] port_ff;
    logic hold_ff, spec_ff;
    logic [2:0] mode_q_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_ff <= MSRM_PORT_GPIO;
            hold_ff <= 1'b0;
            spec_ff <= 1'b0;
            mode_q_ff <= MSRM_NSC;
        end else begin
            port_ff <= nxt_port;
            hold_ff <= periph;
            spec_ff <= special;
            mode_q_ff <= mode_ff;
        end
    end

    assign rdata = rdata_ff;
    assign acc_sel = sel_ff;
    assign acc_grant = grant_ff;
    assign mode_out = mode_q_ff;
    assign port_func = port_ff;
    assign cpu_hold = hold_ff;
    assign ext_master_en = hold_ff;
    assign special_mode = spec_ff;
    assign debug_active = dbg_act_ff;

    // ==================================================
    // checks
    property p_reserved;
        @(posedge clock) disable iff (!resetn) strap_take_ff ##1 1'b1 |-> mode_ff != MSRM_NRS;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode kept");

    property p_once;
        @(posedge clock) disable iff (!resetn)
            (!special && wr_ram && $past(wr_once_ff[1]) && wr_once_ff[1]) |=> $stable(ram_base_ff);
    endproperty
    a_once: assert property (p_once) else $error("map written twice in normal mode");

    property p_periph;
        @(posedge clock) disable iff (!resetn) !strap_take_ff && periph |=> periph;
    endproperty
    a_periph: assert property (p_periph) else $error("left peripheral mode");

    property p_rom;
        @(posedge clock) disable iff (!resetn)
            acc.valid && dbg_act_ff && !acc.serial && in_top |=> sel_ff == MSRM_SEL_DBG;
    endproperty
    a_rom: assert property (p_rom) else $error("debug rom lost decode");

    property p_regwin;
        @(posedge clock) disable iff (!resetn) acc.valid && !use_rom && h_reg |=> sel_ff == MSRM_SEL_REG;
    endproperty
    a_regwin: assert property (p_regwin) else $error("register block lost decode");

    property p_ssc;
        @(posedge clock) disable iff (!resetn)
            resetn && strap_take_ff && strap_mode == MSRM_SSC |=> dbg_act_ff;
    endproperty
    a_ssc: assert property (p_ssc) else $error("debug not active in ssc");

    property p_nvm;
        @(posedge clock) disable iff (!resetn) acc.valid && acc.serial && acc.write && nvm |=> !grant_ff;
    endproperty
    a_nvm: assert property (p_nvm) else $error("serial nvm write granted");

    property p_ext;
        @(posedge clock) disable iff (!resetn)
            acc.valid && !use_rom && !(h_reg || h_ram || h_ee || h_fl) && expanded |=> sel_ff == MSRM_SEL_EXT;
    endproperty
    a_ext: assert property (p_ext) else $error("unclaimed address not external");
endmodule
`default_nettype wire

// *** test/msrm_strap_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// board side of the three strap pins
module msrm_strap_model (
    input wire logic clock,
    input wire logic board_drive,
    input wire logic [2:0] board_level,
    input wire logic debug_strap_oe,
    input wire logic debug_strap_out,
    input wire logic mode_strap_oe,
    input wire logic mode_strap_out,
    output logic [2:0] pins
);
    logic [2:0] last_ff = 3'h0;
    // an open pin with no pull shows the inverse of its last level, so nothing passes by luck
    always_comb begin
        if (board_drive) begin
            pins = board_level;
        end else begin
            pins[2] = debug_strap_oe ? debug_strap_out : ~last_ff[2];
            pins[1:0] = mode_strap_oe ? {2{mode_strap_out}} : ~last_ff[1:0];
        end
    end
    always @(posedge clock) last_ff <= pins;
endmodule
`default_nettype wire

// *** test/msrm_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module msrm_core_test import msrm_pkg::*;;
    logic clock = 0, resetn = 0, wr = 0, rd = 0, serial_enter = 0, enter_debug_instruction = 0, bus_idle = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    msrm_acc_t acc = '0;
    logic board_drive = 1, dbg_oe, dbg_out, mode_oe, mode_out_pin, acc_grant, cpu_hold, ext_en, special_mode;
    logic debug_active, rd_seen = 0, acc_seen = 0;
    logic [2:0] board_level = 3'h4, pins, acc_sel, mode_out, m, r4;
    logic [1:0] port_func;
    logic [7:0] rd_notes[$];
    logic [4:0] acc_notes[$], note;
    int err_total = 0, comparisons = 0, cycles = 0;
    always #50 clock = ~clock;
    msrm_strap_model board (.clock(clock), .board_drive(board_drive), .board_level(board_level),
        .debug_strap_oe(dbg_oe), .debug_strap_out(dbg_out), .mode_strap_oe(mode_oe),
        .mode_strap_out(mode_out_pin), .pins(pins));
    msrm_core uut (.clock(clock), .resetn(resetn), .debug_strap_pin(pins[2]), .mode_strap_high(pins[1]),
        .mode_strap_low(pins[0]), .debug_strap_oe(dbg_oe), .debug_strap_out(dbg_out),
        .mode_strap_oe(mode_oe), .mode_strap_out(mode_out_pin), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .acc(acc), .serial_enter(serial_enter),
        .enter_debug_instruction(enter_debug_instruction), .bus_idle(bus_idle), .acc_sel(acc_sel),
        .acc_grant(acc_grant), .mode_out(mode_out), .port_func(port_func), .cpu_hold(cpu_hold),
        .ext_master_en(ext_en), .special_mode(special_mode), .debug_active(debug_active));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==================================================
    // result watcher: one note per read or access
    always @(posedge clock) begin
        if (rd_seen) check(rdata, (rd_notes.size() > 0) ? rd_notes.pop_front() : 8'hxx, "read");
        if (acc_seen) begin
            note = (acc_notes.size() > 0) ? acc_notes.pop_front() : 5'h00;
            check({5'h0, acc_sel}, {5'h0, note[2:0]}, "select");
            if (note[4]) check({7'h0, acc_grant}, {7'h0, note[3]}, "grant");
        end
        rd_seen <= rd;
        acc_seen <= acc.valid;
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a; rd <= 1'b1;
        rd_notes.push_back(exp);
        @(posedge clock);
        rd <= 1'b0;
    endtask
    // kind is {vector, serial, write}; g is {grant checked, grant expected}
    task automatic access(input logic [15:0] a, input logic [2:0] kind, input msrm_sel_t s, input logic [1:0] g);
        @(posedge clock);
        acc <= {a, 1'b1, kind};
        acc_notes.push_back({g, s});
        @(posedge clock);
        acc <= '0;
    endtask
    task automatic do_reset(input logic [2:0] code, input logic drive);
        @(posedge clock);
        resetn <= 1'b0; board_drive <= drive; board_level <= code;
        repeat (4) @(posedge clock);
        check({6'h0, dbg_oe, mode_oe}, 8'h03, "pull enable");
        check({6'h0, dbg_out, mode_out_pin}, 8'h02, "pull level");
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask
    initial begin
        void'($urandom(32'heb0c237c));
        // ==================================================
        // strap capture and mode decode
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0], 1'b1);
            m = (c == 6) ? 3'h2 : c[2:0];
            check({5'h0, mode_out}, {5'h0, m}, "mode");
            check({6'h0, port_func}, (m[1:0] == 0) ? 8'h00 : (m[1:0] == 1) ? 8'h01 : 8'h02, "port");
            check({5'h0, special_mode, cpu_hold, ext_en}, {5'h0, ~m[2], m == 2, m == 2}, "flags");
            check({7'h0, debug_active}, {7'h0, m == 0}, "debug out of reset");
            // a mode register write in peripheral mode or normal single chip leaves the mode unchanged
            if (m == 2 || m == 4) begin
                reg_wr(ADDR_MODE, {5'h0, m == 2, 2'b00});
                repeat (3) @(posedge clock);
                #1;
                check({5'h0, mode_out}, {5'h0, m}, "mode change refused");
            end
        end
        do_reset(3'h0, 1'b0);
        check({5'h0, mode_out}, 8'h04, "open straps");
        $display("test straps done");
        // ==================================================
        // write-once mapping in normal mode, free in special mode
        r4 = 3'($urandom);
        do_reset(3'h4, 1'b1);
        reg_rd(ADDR_REG_BASE, {RST_REG_BASE, 4'h0});
        reg_rd(ADDR_RAM_BASE, {RST_RAM_BASE, 4'h0});
        reg_rd(ADDR_EE_BASE, {RST_EE_BASE, 4'h0});
        reg_wr(ADDR_RAM_BASE, {1'b1, r4, 4'h0});
        reg_wr(ADDR_RAM_BASE, {1'b0, ~r4, 4'h0});
        reg_rd(ADDR_RAM_BASE, {1'b1, r4, 4'h0});
        do_reset(3'h0, 1'b1);
        reg_wr(ADDR_RAM_BASE, {1'b1, r4, 4'h0});
        reg_wr(ADDR_RAM_BASE, {1'b0, ~r4, 4'h0});
        reg_rd(ADDR_RAM_BASE, {1'b0, ~r4, 4'h0});
        $display("test mapping done");
        // ==================================================
        // decode and precedence in normal expanded narrow
        do_reset(3'h5, 1'b1);
        access(16'h0000, 3'h0, MSRM_SEL_REG, 2'b00);
        access(16'h1000, 3'h0, MSRM_SEL_EE, 2'b00);
        access(16'hc000, 3'h0, MSRM_SEL_FLASH, 2'b00);
        access(16'h5000, 3'h0, MSRM_SEL_EXT, 2'b00);
        reg_wr(ADDR_REG_BASE, 8'h10); // the task's idle edge stands for the no-op
        access(16'h1000, 3'h0, MSRM_SEL_REG, 2'b00);
        bus_idle <= 1'b1;
        access(16'hc000, 3'h2, MSRM_SEL_FLASH, 2'b11);
        access(16'hc000, 3'h3, MSRM_SEL_FLASH, 2'b10);
        access(16'h1000, 3'h3, MSRM_SEL_REG, 2'b11);
        bus_idle <= 1'b0;
        access(16'hc000, 3'h2, MSRM_SEL_FLASH, 2'b10);
        $display("test decode done");
        // ==================================================
        // debug entry and rom overlay in normal single chip
        do_reset(3'h4, 1'b1);
        access(16'h5000, 3'h0, MSRM_SEL_NONE, 2'b00);
        for (int k = 0; k < 4; k++) begin
            if (k == 1 || k == 3) reg_wr(ADDR_DBG_CTL, 8'h01);
            @(posedge clock);
            if (k < 2) enter_debug_instruction <= 1'b1;
            else serial_enter <= 1'b1;
            @(posedge clock);
            enter_debug_instruction <= 1'b0;
            serial_enter <= 1'b0;
            repeat (2) @(posedge clock);
            #1;
            check({7'h0, debug_active}, {7'h0, k[0]}, "debug entry");
            if (k == 1) begin
                access(16'hff00, 3'h0, MSRM_SEL_DBG, 2'b00);
                access(16'hfffe, 3'h4, MSRM_SEL_DBG, 2'b00);
                access(16'hff80, 3'h0, MSRM_SEL_DBG, 2'b00);
                access(16'hff80, 3'h2, MSRM_SEL_FLASH, 2'b00);
                reg_wr(ADDR_DBG_CTL, 8'h00);
            end
        end
        $display("test debug done");
        stop_test();
    end
endmodule
`default_nettype wire
